// File: qdac_host_model.sv
// Purpose: behavioural serial master driving the write port
// Assumes: link clock 320 ns, idle high, stands still between frames
// Notes: data changes while the clock is high, stable across each fall
`timescale 1ns/1ps
`default_nettype none
module qdac_host_model (
  // serial lines toward the port
  output logic frame_sel_b_out,
  output logic sclk_out,
  output logic sdata_out
);
  initial begin
    frame_sel_b_out = 1'b1;
    sclk_out = 1'b1;
    sdata_out = 1'b0;
  end
  // send n bits msb first; fewer than 24 aborts the frame
  task send(input logic [31:0] v, input int n);
    #7 frame_sel_b_out = 1'b0;
    for (int i = 0; i < n; i++) begin
      sdata_out = v[31-i];
      #160 sclk_out = 1'b0;
      #160 sclk_out = 1'b1;
    end
    #160 frame_sel_b_out = 1'b1;
    sdata_out = ~sdata_out; // released line must not look held
    #800;
  endtask : send
endmodule : qdac_host_model
`default_nettype wire

// File: qdac_pkg.sv
// Purpose: shared constants and types for the quad converter serial write port
// Assumes: one 25 MHz system clock, serial pins sampled by two-flop synchronisers
// Notes: register map holds the bus-visible copies of the channel state
package qdac_pkg;
  // ************************************************
  // frame layout
  // ************************************************
  localparam int unsigned FRAME_BITS = 24;
  localparam int unsigned DATA_BITS = 16;
  localparam int unsigned NUM_CH = 4;
  localparam int unsigned BIT_ADDR1 = 23;
  localparam int unsigned BIT_ADDR0 = 22;
  localparam int unsigned BIT_LDHI = 21;
  localparam int unsigned BIT_LDLO = 20;
  localparam int unsigned BIT_CHHI = 18;
  localparam int unsigned BIT_CHLO = 17;
  localparam int unsigned BIT_PD = 16;
  localparam int unsigned BIT_PDHI = 15;
  localparam int unsigned BIT_PDLO = 14;
  localparam logic [4:0] CNT_FULL = 5'h18;
  localparam logic [4:0] CNT_ZERO = 5'h00;
  // channel word: powerdown flag, mode code, data value
  localparam int unsigned CH_W = 19;
  localparam logic [18:0] CH_RESET = 19'h0_0000;
  // ************************************************
  // load commands
  // ************************************************
  typedef enum logic [1:0] {
    CMD_STORE,
    CMD_UPDATE_ONE,
    CMD_UPDATE_SIM,
    CMD_BROADCAST
  } load_cmd_type;
  // ************************************************
  // axi4-lite map, byte addresses
  // ************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_BUF0 = 8'h10;
  localparam logic [7:0] OFS_DAC0 = 8'h20;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : qdac_pkg

// File: qdac_serial_port.sv
// Purpose: serial write front end of a quad 16-bit converter, with axi4-lite status view
// Assumes: serial clock well below half of mclk (bench runs 320 ns)
// Notes: channel words are {powerdown_flag, mode[1:0], data[15:0]}
`timescale 1ns/1ps
`default_nettype none
module qdac_serial_port (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // serial pins
  input wire logic frame_sel_b_in,
  input wire logic sclk_in,
  input wire logic sdata_in,
  input wire logic port_en_b_in,
  input wire logic load_all_strobe_in,
  input wire logic addr_strap_0_in,
  input wire logic addr_strap_1_in,
  // converter outputs, one word per channel
  output logic [qdac_pkg::CH_W*qdac_pkg::NUM_CH-1:0] dac_words_out,
  output logic dac_update_out,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import qdac_pkg::*;

  // ************************************************
  // pin synchronisers
  // ************************************************
  logic [6:0] pins_s;
  // idle levels preset: select high, clock high, port off until the pin is seen
  qdac_sync #(.W(7), .INIT(7'h68)) u_qdac_sync (
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .async_in({frame_sel_b_in, sclk_in, sdata_in, port_en_b_in, load_all_strobe_in,
               addr_strap_1_in, addr_strap_0_in}),
    .sync_out(pins_s)
  );
  wire fs_b_s = pins_s[6];
  wire sclk_s = pins_s[5];
  wire din_s = pins_s[4];
  wire en_b_s = pins_s[3];
  wire strobe_s = pins_s[2];
  wire strap1_s = pins_s[1];
  wire strap0_s = pins_s[0];

  // edge history on synchronised levels
  logic sclk_d_ff;
  logic fs_d_ff;
  logic strobe_d_ff;
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sclk_d_ff <= 1'b1;
      fs_d_ff <= 1'b1;
      strobe_d_ff <= 1'b0;
    end else begin
      sclk_d_ff <= sclk_s;
      fs_d_ff <= fs_b_s;
      strobe_d_ff <= strobe_s;
    end
  end

  // ************************************************
  // control registers (software steers port gating)
  // ************************************************
  logic [31:0] ctrl_ff;
  logic [15:0] frames_ok_ff;
  logic [15:0] frames_abort_ff;
  wire sw_port_off = ctrl_ff[0];

  // ************************************************
  // shift register and frame counter
  // ************************************************
  logic [FRAME_BITS-1:0] shift_ff;
  logic [4:0] count_ff;
  wire port_on = !en_b_s && !sw_port_off;
  wire frame_on = port_on && !fs_b_s;
  wire sclk_fall = sclk_d_ff && !sclk_s;
  wire locked = (count_ff == CNT_FULL);
  wire shift_en = frame_on && sclk_fall && !locked;
  wire word_done = shift_en && (count_ff == CNT_FULL - 5'h01);
  wire aborted = port_on && fs_b_s && !fs_d_ff && !locked && (count_ff != CNT_ZERO);
  wire [FRAME_BITS-1:0] word = {shift_ff[FRAME_BITS-2:0], din_s};

  // shifter; counter clears whenever the frame select is high
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      shift_ff <= '0;
      count_ff <= CNT_ZERO;
    end else if (!frame_on) begin
      count_ff <= CNT_ZERO;
    end else if (shift_en) begin
      shift_ff <= word;
      count_ff <= count_ff + 5'h01;
    end
  end

  // ************************************************
  // command decode
  // ************************************************
  load_cmd_type cmd;
  assign cmd = load_cmd_type'({word[BIT_LDHI], word[BIT_LDLO]});
  wire addr_hit = (word[BIT_ADDR1] == strap1_s) && (word[BIT_ADDR0] == strap0_s);
  wire bcast = (cmd == CMD_BROADCAST);
  wire accept = word_done && (addr_hit || bcast);
  wire [1:0] sel = {word[BIT_CHHI], word[BIT_CHLO]};
  // powerdown takes the mode code from the top data bits and clears the data
  wire [CH_W-1:0] new_word = word[BIT_PD] ?
    {1'b1, word[BIT_PDHI], word[BIT_PDLO], 16'h0000} :
    {1'b0, 2'b00, word[DATA_BITS-1:0]};
  wire strobe_rise = strobe_s && !strobe_d_ff;

  // ************************************************
  // channel buffers and dac registers
  // ************************************************
  logic [CH_W-1:0] buf_ff [NUM_CH];
  logic [CH_W-1:0] dac_ff [NUM_CH];
  logic [NUM_CH-1:0] buf_wr;
  logic [NUM_CH-1:0] dac_new;
  logic [NUM_CH-1:0] dac_from_buf;

  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      buf_wr[i] = 1'b0;
      dac_new[i] = 1'b0;
      dac_from_buf[i] = strobe_rise;
      if (accept) begin
        case (cmd)
          CMD_STORE: begin
            buf_wr[i] = (sel == 2'(i));
          end
          CMD_UPDATE_ONE: begin
            buf_wr[i] = (sel == 2'(i));
            dac_new[i] = (sel == 2'(i));
          end
          CMD_UPDATE_SIM: begin
            buf_wr[i] = (sel == 2'(i));
            dac_new[i] = (sel == 2'(i));
            dac_from_buf[i] = (sel != 2'(i));
          end
          CMD_BROADCAST: begin
            buf_wr[i] = word[BIT_CHHI];
            dac_new[i] = word[BIT_CHHI];
            dac_from_buf[i] = !word[BIT_CHHI];
          end
          default: begin
            buf_wr[i] = 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (int i = 0; i < NUM_CH; i++) begin
        buf_ff[i] <= CH_RESET;
        dac_ff[i] <= CH_RESET;
      end
      dac_update_out <= 1'b0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (buf_wr[i]) buf_ff[i] <= new_word;
        if (dac_new[i]) dac_ff[i] <= new_word;
        else if (dac_from_buf[i]) dac_ff[i] <= buf_ff[i];
      end
      dac_update_out <= |(dac_new | dac_from_buf);
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      dac_words_out[i*CH_W +: CH_W] = dac_ff[i];
    end
  end

  // frame counters for software
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      frames_ok_ff <= 16'h0000;
      frames_abort_ff <= 16'h0000;
    end else begin
      if (accept) frames_ok_ff <= frames_ok_ff + 16'h0001;
      if (aborted) frames_abort_ff <= frames_abort_ff + 16'h0001;
    end
  end

  // ************************************************
  // axi4-lite slave
  // ************************************************
  logic aw_got_ff;
  logic w_got_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  wire wr_go = aw_got_ff && w_got_ff && !s_axi_bvalid;
  wire wr_ctrl = (awaddr_ff == OFS_CTRL);
  wire [1:0] rd_ch = s_axi_araddr[3:2];
  wire rd_buf = (s_axi_araddr[7:4] == OFS_BUF0[7:4]);
  wire rd_dac = (s_axi_araddr[7:4] == OFS_DAC0[7:4]);
  wire rd_ok = (s_axi_araddr == OFS_CTRL) || (s_axi_araddr == OFS_STATUS) || rd_buf || rd_dac;
  wire [31:0] rd_val =
    (s_axi_araddr == OFS_CTRL) ? ctrl_ff :
    (s_axi_araddr == OFS_STATUS) ? {frames_abort_ff, frames_ok_ff} :
    rd_buf ? {13'h0000, buf_ff[rd_ch]} :
    rd_dac ? {13'h0000, dac_ff[rd_ch]} : 32'h0000_0000;

  // write channels, taken in either order
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_got_ff && s_axi_awvalid && !s_axi_awready;
      s_axi_wready <= !w_got_ff && s_axi_wvalid && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
      end
      if (wr_go) begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
      end
    end
  end

  // write response and control register
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl_ff <= CTRL_RESET;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ctrl ? RESP_OKAY : RESP_SLVERR;
        if (wr_ctrl && wdata_ff[0] == 1'b1 && 1'b1) ctrl_ff <= {31'h0, 1'b1};
        if (wr_ctrl && !wdata_ff[0]) ctrl_ff <= CTRL_RESET;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read channel, one word per request
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : qdac_serial_port
`default_nettype wire

// File: qdac_serial_port_properties.sv
// Purpose: concurrent checks on the serial write port outputs
// Assumes: one mclk domain, reset asynchronous and active low
// Notes: sees only top-level ports, bound below
`timescale 1ns/1ps
`default_nettype none
module qdac_serial_port_properties (
  // clock, reset and pins
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic frame_sel_b_in,
  input wire logic load_all_strobe_in,
  // converter side
  input wire logic [qdac_pkg::CH_W*qdac_pkg::NUM_CH-1:0] dac_words_out,
  input wire logic dac_update_out,
  // bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import qdac_pkg::*;
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_b_in);
  // an update strobe is a single-cycle event
  upd_pulse_a: assert property (dac_update_out |=> !dac_update_out)
    else $error("update pulse too long");
  word_flag_a: assert property ($changed(dac_words_out) |-> ##[0:1] dac_update_out)
    else $error("words changed without update");
  // a quiet port must not move the outputs
  idle_hold_a: assert property (
    (frame_sel_b_in && !load_all_strobe_in) [*8] |=> $stable(dac_words_out))
    else $error("outputs moved while idle");
  rst_zero_a: assert property (disable iff (1'b0)
    !rst_b_in |=> dac_words_out == '0 && !dac_update_out)
    else $error("outputs not zero in reset");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  w_answer_a: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid)
    else $error("no write response");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read data");
  aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("address ready held");
  cover property (dac_update_out);
  cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  cover property (s_axi_rvalid && s_axi_rready);
endmodule : qdac_serial_port_properties
bind qdac_serial_port qdac_serial_port_properties u_qdac_serial_port_properties (.mclk_in,
  .rst_b_in, .frame_sel_b_in, .load_all_strobe_in, .dac_words_out, .dac_update_out,
  .s_axi_awvalid, .s_axi_awready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// File: qdac_sync.sv
// Purpose: two flip-flop level synchroniser for pins from outside the clock domain
// Assumes: inputs are slow enough to be sampled by mclk
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module qdac_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // pins
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_ff;
  // two stages, reset to each pin's idle level so no false edge follows reset
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_ff <= INIT;
      sync_out <= INIT;
    end else begin
      meta_ff <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule : qdac_sync
`default_nettype wire

// File: tb_qdac_serial_port.sv
// Purpose: self-checking bench for the serial write port
// Assumes: straps give address 2'b10, full write strobes
// Notes: expected channel state is kept in buf_m and dac_m
`timescale 1ns/1ps
`default_nettype none
module tb_qdac_serial_port;
  import qdac_pkg::*;
  logic mclk_in = 1'b0, rst_b_in = 1'b0, port_en_b_in = 1'b0, load_all_strobe_in = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire logic frame_sel_b_in, sclk_in, sdata_in, dac_update_out;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic [CH_W*NUM_CH-1:0] dac_words_out;
  logic [18:0] buf_m [4], dac_m [4];
  int err_total = 0, checked = 0;
  always #20 mclk_in = ~mclk_in;
  qdac_host_model u_qdac_host_model (.frame_sel_b_out(frame_sel_b_in), .sclk_out(sclk_in),
    .sdata_out(sdata_in));
  qdac_serial_port u_qdac_serial_port (.mclk_in, .rst_b_in, .frame_sel_b_in, .sclk_in,
    .sdata_in, .port_en_b_in, .load_all_strobe_in, .addr_strap_0_in(1'b0),
    .addr_strap_1_in(1'b1), .dac_words_out, .dac_update_out, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  task test_done();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  task chk(input logic [75:0] got, input logic [75:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // one bus transfer; answer ready stands from the start until the answer is sampled
  task axi(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    logic [1:0] resp;
    logic [31:0] data;
    n = 0;
    @(posedge mclk_in);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_arvalid <= !wr;
    s_axi_bready <= wr;
    s_axi_rready <= !wr;
    do begin
      @(posedge mclk_in);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while ((wr ? s_axi_bvalid : s_axi_rvalid) !== 1'b1 && n < 60);
    // answer taken at the edge where valid and ready both stand
    resp = wr ? s_axi_bresp : s_axi_rresp;
    data = s_axi_rdata;
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    chk(76'(resp), 76'(r));
    if (!wr) chk(76'(data), 76'(d));
    if (n >= 60) begin
      err_total++;
      $display("Error at %0t: bus answer timed out", $time);
      test_done();
    end
  endtask : axi
  // expected channel word: flag set turns the two top bits into a mode
  function automatic logic [18:0] cw(input logic [23:0] w);
    return w[16] ? {1'b1, w[15:14], 16'h0000} : {3'b000, w[15:0]};
  endfunction : cw
  task frame(input logic [23:0] w);
    u_qdac_host_model.send({w, 8'h00}, 24);
    if (w[21:20] == 2'b11) begin
      for (int i = 0; i < 4; i++) begin
        if (w[18]) buf_m[i] = cw(w);
        dac_m[i] = buf_m[i];
      end
    end else if (w[23:22] == 2'b10) begin
      buf_m[w[18:17]] = cw(w);
      if (w[21:20] == 2'b01) dac_m[w[18:17]] = cw(w);
      if (w[21:20] == 2'b10) for (int i = 0; i < 4; i++) dac_m[i] = buf_m[i];
    end
    chk(dac_words_out, {dac_m[3], dac_m[2], dac_m[1], dac_m[0]});
  endtask : frame
  task t_cmds();
    logic [23:0] tbl [8];
    int n;
    tbl = '{24'h80_1234, 24'h92_ABCD, 24'h85_C000, 24'hA6_5555, 24'h70_FFFF, 24'h54_0F0F,
      24'hF4_4321, 24'h81_4000};
    for (int i = 0; i < 8; i++) frame(tbl[i]);
    axi(1'b0, OFS_BUF0, {13'h0000, buf_m[0]}, RESP_OKAY);
    @(posedge mclk_in);
    load_all_strobe_in <= 1'b1;
    n = 0;
    // one update pulse per strobe rising edge, none on its fall
    for (int i = 0; i < 14; i++) begin
      @(posedge mclk_in);
      if (i == 5) load_all_strobe_in <= 1'b0;
      if (dac_update_out === 1'b1) n++;
    end
    chk(76'(n), 76'h1);
    for (int i = 0; i < 4; i++) dac_m[i] = buf_m[i];
    chk(dac_words_out, {dac_m[3], dac_m[2], dac_m[1], dac_m[0]});
  endtask : t_cmds
  task t_abort();
    u_qdac_host_model.send(32'h910B_AD00, 10);
    chk(dac_words_out, {dac_m[3], dac_m[2], dac_m[1], dac_m[0]});
    u_qdac_host_model.send(32'h9211_11F0, 28);
    dac_m[1] = 19'h0_1111;
    buf_m[1] = 19'h0_1111;
    chk(dac_words_out, {dac_m[3], dac_m[2], dac_m[1], dac_m[0]});
  endtask : t_abort
  task t_enable();
    @(posedge mclk_in);
    port_en_b_in <= 1'b1;
    u_qdac_host_model.send(32'h9222_2200, 24);
    chk(dac_words_out, {dac_m[3], dac_m[2], dac_m[1], dac_m[0]});
    @(posedge mclk_in);
    port_en_b_in <= 1'b0;
    axi(1'b1, OFS_CTRL, 32'h0000_0001, RESP_OKAY);
    // an update that would move channel 0 unless the port is off
    u_qdac_host_model.send(32'h9033_3300, 24);
    chk(dac_words_out, {dac_m[3], dac_m[2], dac_m[1], dac_m[0]});
    axi(1'b0, OFS_CTRL, 32'h0000_0001, RESP_OKAY);
    axi(1'b1, OFS_CTRL, 32'h0000_0000, RESP_OKAY);
    axi(1'b0, 8'h40, 32'h0000_0000, RESP_SLVERR);
    axi(1'b1, OFS_STATUS, 32'h0000_0005, RESP_SLVERR);
    frame(24'h93_0000);
    // nine accepted frames, one aborted
    axi(1'b0, OFS_STATUS, 32'h0001_0009, RESP_OKAY);
  endtask : t_enable
  initial begin
    repeat (6) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    for (int i = 0; i < 4; i++) buf_m[i] = 19'h0_0000;
    dac_m = buf_m;
    chk(dac_words_out, 76'h0);
    axi(1'b0, OFS_DAC0, 32'h0000_0000, RESP_OKAY);
    t_cmds();
    t_abort();
    t_enable();
    test_done();
  end
  // hang guard
  initial begin
    #2000000 err_total++;
    $display("Error at %0t: run timed out", $time);
    test_done();
  end
endmodule : tb_qdac_serial_port
`default_nettype wire
